//--- verilog/dma_cfg.svh
// offsets, field positions and reset values of the dma controller
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH
`define DMA_NCH 14
`define DMA_RES_MASK 14'h0700
`define DMA_CH_RST 14'h0000
`define DMA_BASE_RST 23'h000000
`define OFS_EN_SET 12'h000
`define OFS_EN_CLR 12'h004
`define OFS_PRI_SET 12'h008
`define OFS_PRI_CLR 12'h00C
`define OFS_SW_REQ 12'h010
`define OFS_TRIG_SEL 12'h014
`define OFS_ALT_SEL 12'h018
`define OFS_BASE 12'h01C
`define OFS_STATUS 12'h020
`define ST_ALT_BIT 32'h00000100
`define ST_SRC_WORD 2'h0
`define ST_DST_WORD 2'h1
`define ST_CFG_WORD 2'h2
`define F_DINC 30
`define F_SINC 26
`define F_SSIZE 24
`define F_RPOW 14
`define F_NM1 4
`define F_MODE 0
`define MODE_STOP 3'h0
`define MODE_PINGPONG 3'h3
`define INC_NONE 2'h3
`endif

//--- verilog/dma_pkg.sv
// types shared by the dma controller modules
package dma_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_READ, ST_WRITE, ST_BACK} state_e;
  typedef logic [13:0] chvec_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_s;
endpackage : dma_pkg

//--- verilog/dma_req_sync.sv
// two-stage synchroniser for the peripheral request pins
`timescale 1ns/10ps
`default_nettype none
module dma_req_sync #(
  parameter int W = 14
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] hold_r;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r[i] <= 1'b0;
          hold_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= async_in[i];
          hold_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate
  assign sync_out = hold_r;
endmodule : dma_req_sync
`default_nettype wire

//--- verilog/dma_arbiter.sv
// two-level fixed priority channel arbiter
`timescale 1ns/10ps
`default_nettype none
`include "dma_cfg.svh"
module dma_arbiter #(
  parameter int NCH = 14,
  parameter logic [NCH-1:0] RES = `DMA_RES_MASK
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NCH-1:0] req,
  input wire logic [NCH-1:0] high,
  output logic gnt_valid,
  output logic [3:0] gnt_idx
);
  logic [NCH-1:0] live;
  logic [NCH-1:0] hi_req;

  function automatic logic [3:0] lowest(input logic [NCH-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int k = NCH - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction : lowest

  assign live = req & ~RES;
  assign hi_req = live & high;
  assign gnt_valid = |live;
  // high level first, then lowest number
  assign gnt_idx = (|hi_req) ? lowest(hi_req) : lowest(live);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  hi_wins_a: assert property ((|hi_req) |-> high[gnt_idx])
    else $error("default channel beat a high channel");
  low_num_a: assert property (gnt_valid |-> live[gnt_idx] && ((((|hi_req) ? hi_req : live) &
    ((NCH'(1) << gnt_idx) - NCH'(1))) == '0))
    else $error("lower channel passed over");
  no_reserved_a: assert property (gnt_valid |-> !RES[gnt_idx])
    else $error("reserved channel granted");
endmodule : dma_arbiter
`default_nettype wire

//--- verilog/dma_controller.sv
// fourteen-slot dma controller with apb registers and a bus master port
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "dma_cfg.svh"
module dma_controller import dma_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [13:0] periph_req,
  output var bus_req_s mst,
  input wire logic m_ready,
  input wire logic m_err,
  input wire logic [31:0] m_rdata,
  output logic [13:0] done_irq,
  output logic err_irq
);
  // ****************************************
  // declarations
  // ****************************************
  state_e state_r;
  bus_req_s mst_r;
  chvec_t en_r, pri_r, trig_sw_r, swpend_r, alt_r, hw_s, req_vec, kill;
  logic [22:0] base_r;
  logic err_r, last_r, pp_r, pready_r, pslverr_r, err_irq_r;
  logic [31:0] prdata_r, sptr_r, dptr_r, cfg_r, data_r, cfg_nxt, rd_mux;
  logic [3:0] ch_r, gidx;
  logic [1:0] idx_r;
  logic [15:0] batch_r;
  logic [13:0] done_irq_r;
  logic gv, xfer_ack, err_hit, fin, stop_hit, apb_wr, apb_rd, rd_bad;
  logic [9:0] rem;

  // ****************************************
  // helper functions
  // ****************************************
  function automatic chvec_t onehot(input logic [3:0] c);
    return chvec_t'(14'h0001 << c);
  endfunction : onehot

  function automatic logic [31:0] struct_addr(input logic [22:0] b, input logic alt,
                                              input logic [3:0] c, input logic [1:0] w);
    logic [31:0] a;
    a = {b, 9'h000} | {24'h000000, c, w, 2'h0};
    if (alt) begin
      a = a | `ST_ALT_BIT;
    end
    return a;
  endfunction : struct_addr

  // final address minus remaining items shifted left by the increment; no increment keeps the pointer
  function automatic logic [31:0] step_addr(input logic [31:0] fin_a,
                                            input logic [9:0] r, input logic [1:0] inc);
    logic [31:0] a;
    a = fin_a;
    if (inc != `INC_NONE) begin
      a = fin_a - ({22'h000000, r} << inc);
    end
    return a;
  endfunction : step_addr

  function automatic logic [1:0] dst_width(input logic [31:0] c);
    logic [1:0] w;
    w = c[`F_DINC+:2];
    if (w == `INC_NONE) begin
      w = c[`F_SSIZE+:2];
    end
    return w;
  endfunction : dst_width

  function automatic logic [31:0] lane_down(input logic [31:0] d, input logic [1:0] a);
    return d >> {a, 3'h0};
  endfunction : lane_down

  function automatic logic [31:0] replicate(input logic [31:0] d, input logic [1:0] w);
    logic [31:0] r;
    case (w)
      2'h0: r = {4{d[7:0]}};
      2'h1: r = {2{d[15:0]}};
      default: r = d;
    endcase
    return r;
  endfunction : replicate

  function automatic logic wr_hit(input logic we, input logic [11:0] a, input logic [11:0] o);
    return we && (a == o);
  endfunction : wr_hit

  // ****************************************
  // request path and arbitration
  // ****************************************
  dma_req_sync #(.W(`DMA_NCH)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(periph_req),
    .sync_out(hw_s)
  );

  // hardware line unless the channel selects software trigger, or software pending on any channel
  assign req_vec = en_r & ~`DMA_RES_MASK & ((hw_s & ~trig_sw_r) | swpend_r);

  dma_arbiter #(.NCH(`DMA_NCH)) u_arb (
    .pclk(pclk),
    .presetn(presetn),
    .req(req_vec),
    .high(pri_r),
    .gnt_valid(gv),
    .gnt_idx(gidx)
  );

  // ****************************************
  // transfer engine
  // ****************************************
  assign xfer_ack = mst_r.valid && m_ready;
  assign err_hit = xfer_ack && m_err;
  assign rem = cfg_r[`F_NM1+:10];
  assign stop_hit = (state_r == ST_FETCH) && xfer_ack && !m_err && (idx_r == `ST_CFG_WORD)
                    && (m_rdata[`F_MODE+:3] == `MODE_STOP);
  assign fin = (state_r == ST_BACK) && xfer_ack && !m_err && last_r;

  always_comb begin
    cfg_nxt = cfg_r;
    if (rem == 10'h000) begin
      cfg_nxt[`F_MODE+:3] = `MODE_STOP;
    end else begin
      cfg_nxt[`F_NM1+:10] = rem - 10'h001;
    end
  end

  // the master holds each request until the bus answers; the bus decides stalls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      mst_r <= '0;
      ch_r <= 4'h0;
      idx_r <= 2'h0;
      sptr_r <= 32'h00000000;
      dptr_r <= 32'h00000000;
      cfg_r <= 32'h00000000;
      data_r <= 32'h00000000;
      batch_r <= 16'h0000;
      last_r <= 1'b0;
      pp_r <= 1'b0;
    end else if (err_hit) begin
      state_r <= ST_IDLE;
      mst_r.valid <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (gv) begin
            ch_r <= gidx;
            idx_r <= `ST_SRC_WORD;
            mst_r <= '{1'b1, 1'b0, 2'h2, struct_addr(base_r, alt_r[gidx], gidx,
                       `ST_SRC_WORD), 32'h00000000};
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (xfer_ack) begin
            if (idx_r == `ST_SRC_WORD) begin
              sptr_r <= m_rdata;
            end
            if (idx_r == `ST_DST_WORD) begin
              dptr_r <= m_rdata;
            end
            if (idx_r != `ST_CFG_WORD) begin
              idx_r <= idx_r + 2'h1;
              mst_r.addr <= struct_addr(base_r, alt_r[ch_r], ch_r, idx_r + 2'h1);
            end else if (stop_hit) begin
              mst_r.valid <= 1'b0;
              state_r <= ST_IDLE;
            end else begin
              cfg_r <= m_rdata;
              pp_r <= m_rdata[`F_MODE+:3] == `MODE_PINGPONG;
              batch_r <= 16'((17'h00001 << m_rdata[`F_RPOW+:4]) - 17'h00001);
              mst_r.size <= m_rdata[`F_SSIZE+:2];
              mst_r.addr <= step_addr(sptr_r, m_rdata[`F_NM1+:10],
                                      m_rdata[`F_SINC+:2]);
              state_r <= ST_READ;
            end
          end
        end
        ST_READ: begin
          if (xfer_ack) begin
            data_r <= lane_down(m_rdata, mst_r.addr[1:0]);
            mst_r.write <= 1'b1;
            mst_r.size <= dst_width(cfg_r);
            mst_r.addr <= step_addr(dptr_r, rem, cfg_r[`F_DINC+:2]);
            mst_r.wdata <= replicate(lane_down(m_rdata, mst_r.addr[1:0]),
                                     cfg_r[`F_SSIZE+:2]);
            state_r <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (xfer_ack) begin
            cfg_r <= cfg_nxt;
            if (rem == 10'h000 || batch_r == 16'h0000) begin
              // progress goes back to sram so the next grant resumes
              last_r <= rem == 10'h000;
              mst_r.size <= 2'h2;
              mst_r.addr <= struct_addr(base_r, alt_r[ch_r], ch_r, `ST_CFG_WORD);
              mst_r.wdata <= cfg_nxt;
              state_r <= ST_BACK;
            end else begin
              batch_r <= batch_r - 16'h0001;
              mst_r.write <= 1'b0;
              mst_r.size <= cfg_r[`F_SSIZE+:2];
              mst_r.addr <= step_addr(sptr_r, rem - 10'h001, cfg_r[`F_SINC+:2]);
              state_r <= ST_READ;
            end
          end
        end
        ST_BACK: begin
          if (xfer_ack) begin
            mst_r.valid <= 1'b0;
            mst_r.write <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          mst_r.valid <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // channel state and software registers
  // ****************************************
  assign apb_wr = psel && penable && pwrite && pready_r;
  assign apb_rd = psel && penable && !pready_r;
  assign kill = (err_hit || stop_hit || (fin && !pp_r)) ? onehot(ch_r) : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= `DMA_CH_RST;
    end else begin
      en_r <= (en_r & ~kill & ~(wr_hit(apb_wr, paddr, `OFS_EN_CLR) ? pwdata[13:0] : '0))
              | (wr_hit(apb_wr, paddr, `OFS_EN_SET) ? pwdata[13:0] & ~`DMA_RES_MASK : '0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_r <= `DMA_CH_RST;
    end else if (wr_hit(apb_wr, paddr, `OFS_PRI_SET)) begin
      pri_r <= pri_r | pwdata[13:0];
    end else if (wr_hit(apb_wr, paddr, `OFS_PRI_CLR)) begin
      pri_r <= pri_r & ~pwdata[13:0];
    end
  end

  // a new software trigger beats the completion clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swpend_r <= `DMA_CH_RST;
    end else begin
      swpend_r <= (swpend_r & ~kill)
                  | (wr_hit(apb_wr, paddr, `OFS_SW_REQ) ? pwdata[13:0] : '0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_sw_r <= `DMA_CH_RST;
      base_r <= `DMA_BASE_RST;
    end else begin
      if (wr_hit(apb_wr, paddr, `OFS_TRIG_SEL)) begin
        trig_sw_r <= pwdata[13:0];
      end
      if (wr_hit(apb_wr, paddr, `OFS_BASE)) begin
        base_r <= pwdata[31:9];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_r <= `DMA_CH_RST;
    end else if (wr_hit(apb_wr, paddr, `OFS_ALT_SEL)) begin
      alt_r <= pwdata[13:0];
    end else if (fin && pp_r) begin
      alt_r <= alt_r ^ onehot(ch_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 1'b0;
    end else begin
      err_r <= err_hit || (err_r && !(wr_hit(apb_wr, paddr, `OFS_STATUS) && pwdata[0]));
    end
  end

  // ****************************************
  // event outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_irq_r <= 14'h0000;
      err_irq_r <= 1'b0;
    end else begin
      done_irq_r <= fin ? onehot(ch_r) : 14'h0000;
      err_irq_r <= err_hit;
    end
  end

  // ****************************************
  // apb slave, one wait state
  // ****************************************
  always_comb begin
    rd_bad = 1'b0;
    case (paddr)
      `OFS_EN_SET, `OFS_EN_CLR: rd_mux = {18'h00000, en_r};
      `OFS_PRI_SET, `OFS_PRI_CLR: rd_mux = {18'h00000, pri_r};
      `OFS_SW_REQ: rd_mux = {18'h00000, swpend_r};
      `OFS_TRIG_SEL: rd_mux = {18'h00000, trig_sw_r};
      `OFS_ALT_SEL: rd_mux = {18'h00000, alt_r};
      `OFS_BASE: rd_mux = {base_r, 9'h000};
      `OFS_STATUS: rd_mux = {20'h00000, ch_r, 6'h00, state_r != ST_IDLE, err_r};
      default: begin
        rd_mux = 32'h00000000;
        rd_bad = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= apb_rd;
      pslverr_r <= apb_rd && rd_bad;
      prdata_r <= (apb_rd && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign mst = mst_r;
  assign done_irq = done_irq_r;
  assign err_irq = err_irq_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence fetch_first;
    state_r == ST_FETCH && xfer_ack && !m_err && idx_r == `ST_SRC_WORD;
  endsequence
  sequence err_pulse;
    err_irq_r ##1 !err_irq_r;
  endsequence

  bus_hold_a: assert property (mst_r.valid && !m_ready |=> $stable(mst_r))
    else $error("bus request changed before answer");
  err_disable_a: assert property (err_hit |=> !en_r[$past(ch_r)] && state_r == ST_IDLE)
    else $error("faulty channel still enabled");
  err_irq_a: assert property (err_hit |=> err_pulse)
    else $error("error request not one pulse");
  done_irq_a: assert property (fin |=> done_irq_r == onehot($past(ch_r)))
    else $error("completion request wrong");
  fetch_addr_a: assert property (state_r == ST_IDLE && gv |=>
    mst_r.addr == struct_addr(base_r, alt_r[ch_r], ch_r, 2'h0))
    else $error("structure address wrong");
  fetch_next_a: assert property (fetch_first |=> mst_r.addr[3:0] == 4'h4)
    else $error("destination word not fetched next");
  pri_write_a: assert property (wr_hit(apb_wr, paddr, `OFS_PRI_SET) |=>
    (pri_r & $past(pwdata[13:0])) == $past(pwdata[13:0]))
    else $error("priority set ignored");
  no_res_fetch_a: assert property (state_r != ST_IDLE |-> (onehot(ch_r) & `DMA_RES_MASK) == '0)
    else $error("reserved channel fetched");
endmodule : dma_controller
`default_nettype wire

//--- bench/dma_mem_model.sv
// system bus memory model answering the dma master port
`timescale 1ns/10ps
`default_nettype none
module dma_mem_model import dma_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input var bus_req_s mst,
  input wire logic [1:0] lat,
  output logic m_ready,
  output logic m_err,
  output logic [31:0] m_rdata
);
  // ****************************************
  // memory and answer logic
  // ****************************************
  // 1 KiB only: structures below 0x200, data above; top nibble F is reserved space
  logic [31:0] mem [0:255];
  logic [1:0] cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_ready <= 1'b0;
      m_err <= 1'b0;
      m_rdata <= 32'h5A5A5A5A;
      cnt <= 2'h0;
    end else if (mst.valid && !m_ready && cnt != lat) begin
      // slow answer: stall like a contended bus
      cnt <= cnt + 2'h1;
      m_rdata <= ~m_rdata;
    end else if (mst.valid && !m_ready) begin
      cnt <= 2'h0;
      m_ready <= 1'b1;
      m_err <= (mst.addr[31:28] == 4'hF);
      m_rdata <= mem[mst.addr[9:2]];
      if (mst.write && mst.addr[31:28] != 4'hF) begin
        for (int b = 0; b < 4; b++) begin
          if (mst.size == 2'h2 || (mst.size == 2'h1 && b[1] == mst.addr[1]) ||
              (mst.size == 2'h0 && b[1:0] == mst.addr[1:0])) begin
            mem[mst.addr[9:2]][8*b+:8] <= mst.wdata[8*b+:8];
          end
        end
      end
    end else begin
      // released lines never hold the last value
      m_ready <= 1'b0;
      m_err <= 1'b0;
      m_rdata <= ~m_rdata;
    end
  end
endmodule : dma_mem_model
`default_nettype wire

//--- bench/multichannel_dma_controller_bench.sv
// self-checking bench for the dma controller
`timescale 1ns/10ps
`default_nettype none
`include "dma_cfg.svh"
module multichannel_dma_controller_bench import dma_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, m_ready, m_err, err_irq, err_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, m_rdata, r;
  logic [13:0] periph_req, done_irq, done_seen;
  logic [1:0] lat;
  logic e;
  bus_req_s mst;
  logic [8:0] fq[$];
  int fail_count, checks, cyc;
  dma_controller u_dma_controller (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_req(periph_req), .mst(mst),
    .m_ready(m_ready), .m_err(m_err), .m_rdata(m_rdata), .done_irq(done_irq),
    .err_irq(err_irq));
  dma_mem_model u_dma_mem_model (.pclk(pclk), .presetn(presetn), .mst(mst), .lat(lat),
    .m_ready(m_ready), .m_err(m_err), .m_rdata(m_rdata));
  // ****************************************
  // clock, monitors, timeout
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    done_seen <= done_seen | done_irq;
    err_seen <= err_seen | err_irq;
    if (mst.valid && m_ready && !mst.write && mst.addr[3:0] == 4'h0 && mst.addr < 32'h200) begin
      fq.push_back(mst.addr[8:0]);
    end
    if (cyc > 20000) begin
      fail_count++;
      $display("ERROR %0t: timeout", $time);
      stop_test();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task stop_test;
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no limit of its own: only the bench timeout ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(r & m, exp);
  endtask : rd
  // byte, half or word widths, 0 rearbitration power, basic mode
  function automatic logic [31:0] cw(input logic [1:0] w, input logic [9:0] n);
    return {w, 2'h0, w, w, 6'h0, 4'h0, n - 10'd1, 1'b0, 3'h1};
  endfunction : cw
  task st(input int ch, input int alt, input logic [31:0] s, input logic [31:0] d,
          input logic [31:0] c);
    int i;
    i = (ch * 16 + alt * 256) / 4;
    u_dma_mem_model.mem[i] = s;
    u_dma_mem_model.mem[i + 1] = d;
    u_dma_mem_model.mem[i + 2] = c;
    u_dma_mem_model.mem[i + 3] = 32'h0;
  endtask : st
  task wait_en(input logic [31:0] m);
    do begin
      apb(1'b0, `OFS_EN_SET, 32'h0);
    end while ((r & m) !== 32'h0);
  endtask : wait_en
  task go(input logic [31:0] m);
    fq.delete();
    apb(1'b1, `OFS_EN_SET, m);
    apb(1'b1, `OFS_SW_REQ, m);
    wait_en(m);
  endtask : go
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, periph_req, lat, presetn} = '0;
    {fail_count, checks, cyc, done_seen, err_seen} = '0;
    foreach (u_dma_mem_model.mem[i]) u_dma_mem_model.mem[i] = {24'hA5C300, i[7:0]};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_EN_SET, 32'h0, 32'hFFFFFFFF);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    apb(1'b1, `OFS_EN_SET, 32'h3FFF);
    rd(`OFS_EN_SET, 32'h38FF, 32'h3FFF);
    apb(1'b1, `OFS_EN_CLR, 32'h3FFF);
    rd(`OFS_EN_SET, 32'h0, 32'h3FFF);
    apb(1'b1, `OFS_TRIG_SEL, 32'h30FF);
    lat <= 2'h3;
    st(0, 0, 32'h208, 32'h308, cw(2'h2, 10'd3));
    go(32'h1);
    for (int i = 0; i < 3; i++) chk(u_dma_mem_model.mem[8'hC0 + i], {24'hA5C300, 8'(8'h80 + i)});
    chk(u_dma_mem_model.mem[8'hC3], 32'hA5C300C3);
    lat <= 2'h0;
    for (int h = 0; h < 2; h++) begin
      st(1, 0, 32'h210, 32'h310, cw(2'h2, 10'd1));
      st(2, 0, 32'h214, 32'h314, cw(2'h2, 10'd1));
      if (h == 1) apb(1'b1, `OFS_PRI_SET, 32'h4);
      go(32'h6);
      chk({23'h0, fq[0]}, (h == 1) ? 32'h020 : 32'h010);
    end
    st(12, 1, 32'h218, 32'h318, cw(2'h2, 10'd1));
    apb(1'b1, `OFS_ALT_SEL, 32'h1000);
    go(32'h1000);
    chk({23'h0, fq[0]}, 32'h1C0);
    chk(u_dma_mem_model.mem[8'hC6], 32'hA5C30086);
    st(13, 0, 32'h223, 32'h323, cw(2'h0, 10'd4));
    go(32'h2000);
    chk(u_dma_mem_model.mem[8'hC8], 32'hA5C30088);
    st(11, 0, 32'h224, 32'h324, cw(2'h2, 10'd1));
    fq.delete();
    apb(1'b1, `OFS_EN_SET, 32'h0800);
    periph_req <= 14'h0A00;
    wait_en(32'h0800);
    periph_req <= 14'h0;
    chk(fq.size(), 32'h1);
    chk({23'h0, fq[0]}, 32'h0B0);
    chk(u_dma_mem_model.mem[8'hC9], 32'hA5C30089);
    st(3, 0, 32'hF0000000, 32'h328, cw(2'h2, 10'd1));
    go(32'h8);
    chk({31'h0, err_seen}, 32'h1);
    rd(`OFS_STATUS, 32'h1, 32'h1);
    apb(1'b1, `OFS_STATUS, 32'h1);
    rd(`OFS_STATUS, 32'h0, 32'h1);
    chk({18'h0, done_seen}, 32'h3807);
    stop_test();
  end
endmodule : multichannel_dma_controller_bench
`default_nettype wire
